// *** src/amp_prot_pkg.sv ***
// package: constants and types for the amplifier protection sequencer
package amp_prot_pkg;
    localparam int unsigned CLK_FREQ_HZ       = 50_000_000;
    localparam int unsigned RESTART_MS        = 100;
    localparam int unsigned RESTART_CYCLES    = (CLK_FREQ_HZ / 1000) * RESTART_MS;
    localparam int unsigned OCP_LIMIT_US      = 100;
    localparam int unsigned OCP_LIMIT_CYCLES  = (CLK_FREQ_HZ / 1_000_000) * OCP_LIMIT_US;
    localparam int unsigned MUTE_HOLD_MS      = 50;
    localparam int unsigned MUTE_HOLD_CYCLES  = (CLK_FREQ_HZ / 1000) * MUTE_HOLD_MS;
    localparam int unsigned SOFTOFF_US        = 200;
    localparam int unsigned SOFTOFF_CYCLES    = (CLK_FREQ_HZ / 1_000_000) * SOFTOFF_US;
    localparam int unsigned FOLD_STEP_US      = 20;
    localparam int unsigned FOLD_STEP_CYCLES  = (CLK_FREQ_HZ / 1_000_000) * FOLD_STEP_US;
    localparam int unsigned CNT_W             = 23;
    localparam int unsigned FOLD_W            = 4;
    localparam logic [3:0]  FOLD_MAX          = 4'hc;
    localparam logic [1:0]  MODE_STANDBY      = 2'h0;
    localparam logic [1:0]  MODE_MUTE         = 2'h1;
    localparam logic [1:0]  MODE_OPERATE      = 2'h2;

    typedef struct packed {
        logic temp_fold;
        logic over_temp;
        logic current_limit;
        logic low_z_short;
        logic rail_short;
        logic under_volt;
        logic over_volt;
        logic supply_unbalance;
    } fault_in_t;

    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_WINDOW,
        ST_MUTE,
        ST_OPERATE,
        ST_SOFTOFF,
        ST_SHUTDOWN
    } seq_state_t;
endpackage : amp_prot_pkg

// *** src/amp_fault_protection_sequencer.sv ***
// amplifier fault protection and startup sequencer
`timescale 1ns/1ps
module amp_fault_protection_sequencer
    import amp_prot_pkg::*;
(
    input  wire logic             clock_i,          // 50 MHz oscillator clock
    input  wire logic             srst_i,           // synchronous reset, active high
    input  wire logic [1:0]       mode_i,           // standby / mute / operating
    input  wire fault_in_t        fault_i,          // analog comparator indications
    input  wire logic             internal_clk_i,   // internal oscillator in use
    output logic                  power_stage_en_o, // output switching enable
    output logic                  input_stage_en_o, // VI input stages enable
    output logic                  current_clamp_o,  // clamp output current
    output logic [FOLD_W-1:0]     gain_reduce_o,    // gain foldback, 0.5 dB steps
    output logic                  window_test_o,    // rail-short test active
    output logic                  fault_out_o,      // diagnostic overcurrent output
    output logic [2:0]            state_o           // sequencer state
);
    // =====================================================================
    // input synchronisers
    fault_in_t  flt_meta;
    fault_in_t  flt;
    logic [1:0] mode_meta;
    logic [1:0] mode;
    logic       iclk_meta;
    logic       iclk;

    always_ff @(posedge clock_i) begin
        flt_meta  <= fault_i;
        flt       <= flt_meta;
        mode_meta <= mode_i;
        mode      <= mode_meta;
        iclk_meta <= internal_clk_i;
        iclk      <= iclk_meta;
    end

    // =====================================================================
    // fault classification
    seq_state_t       state;
    seq_state_t       next_state;
    logic [CNT_W-1:0] ocp_cnt;
    logic [CNT_W-1:0] tmr;
    logic [FOLD_W-1:0] fold;
    logic [CNT_W-1:0] fold_tmr;
    logic             ocp_trip;
    logic             prev_standby;

    wire ocp_timeout  = flt.current_limit && (ocp_cnt >= CNT_W'(OCP_LIMIT_CYCLES - 1));
    wire ocp_shutdown = flt.low_z_short || ocp_timeout;
    // shutdown-class faults; rail short is deliberately absent: it only stalls startup
    wire hard_fault   = flt.over_temp || flt.over_volt || flt.supply_unbalance
                      || ocp_shutdown;
    wire any_fault    = hard_fault || flt.under_volt || ocp_trip;
    wire standby_req  = (mode == MODE_STANDBY);
    wire enter_window = prev_standby && !standby_req;
    wire running      = (state == ST_MUTE) || (state == ST_OPERATE);

    // =====================================================================
    // overcurrent limiting timer and latch
    always_ff @(posedge clock_i) begin
        if (srst_i || !flt.current_limit || !running) begin
            ocp_cnt <= '0;
        end else if (ocp_cnt != CNT_W'(OCP_LIMIT_CYCLES - 1)) begin
            ocp_cnt <= ocp_cnt + CNT_W'(1);
        end
    end

    // latch holds the trip until reset: as a fault it keeps reloading the restart delay, so fault output stays up
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ocp_trip <= 1'b0;
        end else if (running && ocp_shutdown) begin
            ocp_trip <= 1'b1;
        end else if (state == ST_SHUTDOWN && tmr == '0 && !hard_fault) begin
            ocp_trip <= 1'b0;
        end
    end

    // =====================================================================
    // sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_STANDBY: begin
                if (enter_window) begin
                    next_state = ST_WINDOW;
                end
            end
            ST_WINDOW: begin
                if (standby_req) begin
                    next_state = ST_STANDBY;
                end else if (hard_fault) begin
                    next_state = ST_SHUTDOWN;
                end else if (!flt.rail_short) begin
                    next_state = ST_MUTE;
                end
            end
            ST_MUTE, ST_OPERATE: begin
                if (hard_fault) begin
                    next_state = ST_SHUTDOWN;
                end else if (flt.under_volt) begin
                    next_state = ST_SOFTOFF;
                end else if (standby_req) begin
                    next_state = ST_STANDBY;
                end else if (state == ST_MUTE && mode == MODE_OPERATE && tmr == '0) begin
                    next_state = ST_OPERATE;
                end else if (state == ST_OPERATE && mode == MODE_MUTE) begin
                    next_state = ST_MUTE;
                end
            end
            ST_SOFTOFF: begin
                if (hard_fault || tmr == '0) begin
                    next_state = ST_SHUTDOWN;
                end
            end
            ST_SHUTDOWN: begin
                if (standby_req) begin
                    next_state = ST_STANDBY;
                end else if (!any_fault && tmr == '0) begin
                    next_state = ST_WINDOW;
                end
            end
            default: next_state = ST_STANDBY;
        endcase
    end

    // soft-off ramp only when the internal clock keeps running
    wire [CNT_W-1:0] softoff_load = iclk ? CNT_W'(SOFTOFF_CYCLES - 1) : CNT_W'(0);

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state        <= ST_STANDBY;
            tmr          <= '0;
            prev_standby <= 1'b1;
        end else begin
            state        <= next_state;
            prev_standby <= standby_req;
            if (next_state == ST_SHUTDOWN && any_fault) begin
                tmr <= CNT_W'(RESTART_CYCLES - 1);
            end else if (state == ST_WINDOW && next_state == ST_MUTE) begin
                tmr <= CNT_W'(MUTE_HOLD_CYCLES - 1);
            end else if (state != ST_SOFTOFF && next_state == ST_SOFTOFF) begin
                tmr <= softoff_load;
            end else if (tmr != '0) begin
                tmr <= tmr - CNT_W'(1);
            end
        end
    end

    // =====================================================================
    // thermal gain foldback: one step per interval, up or down
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            fold     <= '0;
            fold_tmr <= '0;
        end else if (fold_tmr != '0) begin
            fold_tmr <= fold_tmr - CNT_W'(1);
        end else begin
            fold_tmr <= CNT_W'(FOLD_STEP_CYCLES - 1);
            if (flt.temp_fold && fold != FOLD_MAX) begin
                fold <= fold + FOLD_W'(1);
            end else if (!flt.temp_fold && fold != '0) begin
                fold <= fold - FOLD_W'(1);
            end
        end
    end

    // =====================================================================
    // registered outputs
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            power_stage_en_o <= 1'b0;
            input_stage_en_o <= 1'b0;
            current_clamp_o  <= 1'b0;
            gain_reduce_o    <= '0;
            window_test_o    <= 1'b0;
            fault_out_o      <= 1'b0;
            state_o          <= 3'h0;
        end else begin
            power_stage_en_o <= (next_state == ST_MUTE) || (next_state == ST_OPERATE)
                              || (next_state == ST_SOFTOFF);
            input_stage_en_o <= (next_state == ST_OPERATE);
            current_clamp_o  <= flt.current_limit && running;
            gain_reduce_o    <= fold;
            window_test_o    <= (next_state == ST_WINDOW);
            fault_out_o      <= (flt.current_limit && running) || ocp_trip;
            state_o          <= 3'(next_state);
        end
    end

    // =====================================================================
    // checks
    AST_OTP_OFF: assert property (@(posedge clock_i) disable iff (srst_i)
        (running && flt.over_temp) |=> !power_stage_en_o)
        else $error("over-temperature did not stop switching");
    AST_WINDOW_NO_POWER: assert property (@(posedge clock_i) disable iff (srst_i)
        window_test_o |-> !power_stage_en_o)
        else $error("power enabled during window check");
    AST_FOLD_NO_FAULT: assert property (@(posedge clock_i) disable iff (srst_i)
        (fault_out_o) |-> ($past(flt.current_limit) || $past(ocp_trip)))
        else $error("fault output without overcurrent cause");
    AST_CLAMP_KEEPS_ON: assert property (@(posedge clock_i) disable iff (srst_i)
        (running && flt.current_limit && !hard_fault && !flt.under_volt
         && !standby_req) |=> power_stage_en_o)
        else $error("current limiting stopped switching");
    AST_RESTART_WAIT: assert property (@(posedge clock_i) disable iff (srst_i)
        (state == ST_SHUTDOWN && any_fault) |=> (tmr == CNT_W'(RESTART_CYCLES - 1)
         || state != ST_SHUTDOWN))
        else $error("restart delay not reloaded under fault");
    AST_RAIL_HOLD: assert property (@(posedge clock_i) disable iff (srst_i)
        (state == ST_WINDOW && flt.rail_short && !standby_req && !hard_fault)
        |=> state == ST_WINDOW)
        else $error("startup passed window with rail short");
    AST_OCP_TRIP: assert property (@(posedge clock_i) disable iff (srst_i)
        (running && flt.low_z_short) |=> ##1 (fault_out_o && !power_stage_en_o))
        else $error("load short did not trip");
    AST_SHUT_EXIT: assert property (@(posedge clock_i) disable iff (srst_i)
        (state == ST_SHUTDOWN && $past(state) == ST_SHUTDOWN && tmr != '0)
        |=> state != ST_WINDOW)
        else $error("restart before delay elapsed");

    // =====================================================================
    // startup and shutdown steps
    sequence seq_leave_standby;
        state == ST_STANDBY && enter_window;
    endsequence : seq_leave_standby

    sequence seq_uv_hit;
        running && flt.under_volt && !hard_fault && !standby_req;
    endsequence : seq_uv_hit

    sequence seq_softoff_done;
        state == ST_SOFTOFF && tmr == '0;
    endsequence : seq_softoff_done

    AST_WINDOW_ENTRY: assert property (@(posedge clock_i) disable iff (srst_i)
        seq_leave_standby |=> (state == ST_WINDOW && window_test_o && !power_stage_en_o))
        else $error("standby exit skipped the window check");
    AST_UV_SOFTOFF: assert property (@(posedge clock_i) disable iff (srst_i)
        seq_uv_hit |=> (state == ST_SOFTOFF && power_stage_en_o))
        else $error("undervoltage did not start the orderly switch-off");
    AST_SOFTOFF_END: assert property (@(posedge clock_i) disable iff (srst_i)
        seq_softoff_done |=> (state == ST_SHUTDOWN && !power_stage_en_o))
        else $error("switch-off ramp did not end in shutdown");
    // a restart never jumps straight back into switching
    AST_RESTART_ROUTE: assert property (@(posedge clock_i) disable iff (srst_i)
        (state == ST_SHUTDOWN) |=> (state == ST_SHUTDOWN || state == ST_WINDOW
         || state == ST_STANDBY))
        else $error("restart bypassed the window check");
    AST_MUTE_HOLD: assert property (@(posedge clock_i) disable iff (srst_i)
        (state == ST_MUTE && tmr != '0) |=> state != ST_OPERATE)
        else $error("operating mode entered before mute hold elapsed");

    // =====================================================================
    // protection outputs
    // foldback alone must never stop the stage
    AST_FOLD_KEEPS_ON: assert property (@(posedge clock_i) disable iff (srst_i)
        (running && flt.temp_fold && !hard_fault && !flt.under_volt && !standby_req)
        |=> power_stage_en_o)
        else $error("foldback stopped switching");
    AST_FOLD_RANGE: assert property (@(posedge clock_i) disable iff (srst_i)
        !(gain_reduce_o > FOLD_MAX))
        else $error("gain reduction beyond its range");
    AST_LIMIT_FLAGGED: assert property (@(posedge clock_i) disable iff (srst_i)
        (running && flt.current_limit) |=> (fault_out_o && current_clamp_o))
        else $error("active limiting not flagged");
    AST_TRIP_HELD: assert property (@(posedge clock_i) disable iff (srst_i)
        (ocp_trip && state == ST_SHUTDOWN) |=> fault_out_o)
        else $error("overcurrent shutdown not flagged");
    AST_LIMIT_TIMEOUT: assert property (@(posedge clock_i) disable iff (srst_i)
        (running && ocp_timeout) |=> (state == ST_SHUTDOWN && !power_stage_en_o))
        else $error("persistent limiting did not shut down");
    AST_SUPPLY_TRIP: assert property (@(posedge clock_i) disable iff (srst_i)
        (running && (flt.over_volt || flt.supply_unbalance)) |=> !power_stage_en_o)
        else $error("supply fault did not stop switching");
    AST_INPUT_OPERATE: assert property (@(posedge clock_i) disable iff (srst_i)
        input_stage_en_o |-> state == ST_OPERATE)
        else $error("input stages enabled outside operating mode");
endmodule : amp_fault_protection_sequencer

// *** tb/amp_analog_model.sv ***
// model of the analog fault comparators and power output stage
`timescale 1ns/1ps
module amp_analog_model
    import amp_prot_pkg::*;
(
    input  wire logic       clock_i,    // oscillator clock
    input  wire logic       power_en_i, // output switching enable
    input  wire logic [1:0] temp_i,     // 0 cool, 1 fold range, 2 hot
    input  wire logic [1:0] load_i,     // 0 normal, 1 impedance drop, 2 short
    input  wire logic       rail_i,     // output shorted to a rail
    input  wire logic [1:0] supply_i,   // 0 ok, 1 under, 2 over, 3 unbalance
    output fault_in_t       fault_o     // comparator levels
);
    // load current flows only while the stage switches
    wire logic overload = power_en_i && (load_i != 2'h0);
    always_ff @(posedge clock_i) begin
        fault_o.temp_fold        <= (temp_i != 2'h0);
        fault_o.over_temp        <= (temp_i == 2'h2);
        fault_o.current_limit    <= overload;
        fault_o.low_z_short      <= overload && (load_i == 2'h2);
        fault_o.rail_short       <= rail_i;
        fault_o.under_volt       <= (supply_i == 2'h1);
        fault_o.over_volt        <= (supply_i == 2'h2);
        fault_o.supply_unbalance <= (supply_i == 2'h3);
    end
endmodule : amp_analog_model

// *** tb/tb.sv ***
// self-checking bench for the amplifier protection sequencer
`timescale 1ns/1ps
module tb
    import amp_prot_pkg::*;
;
    typedef struct packed {
        logic [1:0] temp;
        logic [1:0] load;
        logic       rail;
        logic [1:0] supply;
    } stim_t;
    logic       clock_i = 1'b0;
    logic       srst_i = 1'b1;
    logic [1:0] mode = 2'h0;
    logic       int_clk = 1'b1;
    stim_t      stim = '0;
    fault_in_t  fault;
    logic       power_en, input_en, clamp, win, fault_out;
    logic [3:0] gain;
    logic [2:0] state;
    int         num_errors = 0;
    int         n_checks = 0;
    int         hold;
    logic [7:0] exp_off;
    wire logic [7:0] off_view = {power_en, fault_out, 3'h0, state};

    always #10 clock_i = ~clock_i;

    amp_fault_protection_sequencer dut_u (
        .clock_i(clock_i), .srst_i(srst_i), .mode_i(mode), .fault_i(fault),
        .internal_clk_i(int_clk), .power_stage_en_o(power_en),
        .input_stage_en_o(input_en), .current_clamp_o(clamp), .gain_reduce_o(gain),
        .window_test_o(win), .fault_out_o(fault_out), .state_o(state));
    amp_analog_model model_u (
        .clock_i(clock_i), .power_en_i(power_en), .temp_i(stim.temp),
        .load_i(stim.load), .rail_i(stim.rail), .supply_i(stim.supply), .fault_o(fault));

    // ==========================================
    // shared tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : cyc
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        if (num_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // only undervoltage on the internal clock ramps down first
    function automatic logic [2:0] shut_state(input int k, input logic ic);
        return (k == 2 && ic) ? ST_SOFTOFF : ST_SHUTDOWN;
    endfunction : shut_state
    // reset, then standby to mute with a rail short held for hold cycles
    task automatic bring_up(input int hold, input logic ic);
        @(posedge clock_i);
        srst_i <= 1'b1;
        mode <= MODE_STANDBY;
        stim <= '0;
        int_clk <= ic;
        repeat (2) @(posedge clock_i);
        srst_i <= 1'b0;
        cyc(1);
        chk({power_en, input_en, clamp, win, fault_out, state}, 8'h00);
        @(posedge clock_i);
        mode <= MODE_MUTE;
        stim.rail <= (hold > 0);
        cyc(6);
        if (hold > 0) begin
            chk({3'h0, power_en, win, state}, {4'h1, ST_WINDOW});
            cyc(hold);
            chk({3'h0, power_en, win, state}, {4'h1, ST_WINDOW});
            @(posedge clock_i);
            stim.rail <= 1'b0;
            cyc(6);
        end
        chk({2'h0, power_en, input_en, win, state}, {5'h4, ST_MUTE});
    endtask : bring_up

    // ==========================================
    // scenarios
    initial begin
        void'($urandom(32'h00ed));
        bring_up(20 + $urandom % 200, 1'b1);
        @(posedge clock_i);
        stim.temp <= 2'h1;
        cyc(13 * FOLD_STEP_CYCLES + 10);
        chk({power_en, fault_out, 2'h0, gain}, {4'h8, FOLD_MAX});
        hold = 100 + $urandom % 3000;
        @(posedge clock_i);
        stim.load <= 2'h1;
        cyc(6);
        chk({5'h0, power_en, clamp, fault_out}, 8'h07);
        cyc(hold);
        chk({5'h0, power_en, clamp, fault_out}, 8'h07);
        @(posedge clock_i);
        stim.load <= 2'h0;
        cyc(6);
        chk({5'h0, power_en, clamp, fault_out}, 8'h04);
        @(posedge clock_i);
        stim.load <= 2'h1;
        cyc(OCP_LIMIT_CYCLES + 20);
        chk({power_en, fault_out, 3'h0, state}, {5'h8, ST_SHUTDOWN});
        // hard faults and undervoltage: no early restart even after the fault clears
        for (int k = 0; k < 5; k++) begin
            bring_up(($urandom % 2) * 30, 1'($urandom % 2));
            @(posedge clock_i);
            case (k)
                0: stim.temp <= 2'h2;
                1: stim.load <= 2'h2;
                default: stim.supply <= 2'(k - 1);
            endcase
            cyc(8);
            chk({5'h0, state}, {5'h0, shut_state(k, int_clk)});
            if (shut_state(k, int_clk) == ST_SOFTOFF) cyc(SOFTOFF_CYCLES);
            exp_off = {1'b0, k == 1, 3'h0, ST_SHUTDOWN};
            chk(off_view, exp_off);
            @(posedge clock_i);
            stim <= '0;
            mode <= MODE_OPERATE;
            cyc(1000 + $urandom % 2000);
            chk({power_en, 4'h0, state}, {5'h0, ST_SHUTDOWN});
        end
        end_sim;
    end

    // hang guard sized well above the longest scenario sum
    initial begin
        repeat (100000) @(posedge clock_i);
        num_errors++;
        end_sim;
    end
endmodule : tb
